// ==== src/wit_pkg.sv ====
// Package with the register map, field positions, reset values and timing constants of the watchdog interval timer.
package wit_pkg;

    localparam int ADDR_W = 2;
    localparam int WDATA_W = 16;
    localparam int REG_W = 8;

    localparam logic [1:0] OFS_COUNTER = 2'h0;
    localparam logic [1:0] OFS_CONTROL = 2'h1;
    localparam logic [1:0] OFS_RESET_CTRL = 2'h2;

    // Key bytes carried in the upper half of a protected write.
    localparam logic [7:0] KEY_COUNTER = 8'h5A;
    localparam logic [7:0] KEY_CONTROL = 8'hA5;

    localparam int CTRL_FLAG_BIT = 7;
    localparam int CTRL_MODE_BIT = 6;
    localparam int CTRL_RUN_BIT = 5;
    localparam int CTRL_SEL_LSB = 0;
    localparam int RST_FLAG_BIT = 7;
    localparam int RST_ENABLE_BIT = 6;
    localparam int RST_KIND_BIT = 5;

    localparam logic [7:0] COUNTER_RESET = 8'h00;
    localparam logic [7:0] COUNTER_MAX = 8'hFF;
    localparam logic [7:0] CONTROL_ONES = 8'h18;
    localparam logic [7:0] RESET_CTRL_ONES = 8'h1F;
    localparam logic [2:0] SEL_RESET = 3'h0;

    // Divider exponents for select codes 7 down to 0: 13, 12, 10, 9, 8, 7, 6, 1 (ratios 8192 down to 2).
    localparam int PRESCALE_W = 13;
    localparam logic [31:0] DIV_SHIFT_TABLE = 32'hDCA9_8761;

    localparam int CLK_PERIOD_NS = 10;
    localparam int PULSE_NS = 1280;
    localparam int PULSE_CYCLES = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CNT_W = 9;

    typedef enum logic {
        MODE_INTERVAL = 1'b0,
        MODE_WATCHDOG = 1'b1
    } wit_mode_e;

    typedef enum logic {
        PULSE_IDLE = 1'b0,
        PULSE_DRIVE = 1'b1
    } wit_pulse_e;

endpackage

// ==== src/wit_prescaler.sv ====
// Free-running prescaler that gives one-cycle count enables at the selected division ratio.
`timescale 1ns/100ps
module wit_prescaler #(
    parameter int PRESCALE_W = wit_pkg::PRESCALE_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic [2:0] sel_i,
    output logic tick_o
);

    if (PRESCALE_W < 13) begin : g_width_check
        $error("Prescaler too narrow for the largest division ratio.");
    end

    logic [PRESCALE_W-1:0] count_reg;
    logic [PRESCALE_W-1:0] count_next;
    logic tick_reg;
    logic tick_next;

    // Returns the low-bit mask whose all-ones state marks the end of one divided period.
    function automatic logic [PRESCALE_W-1:0] tap_mask(input logic [2:0] sel);
        logic [3:0] shift;
        shift = wit_pkg::DIV_SHIFT_TABLE[sel*4 +: 4];
        tap_mask = PRESCALE_W'((1 << shift) - 1);
    endfunction

    always_comb begin
        if (clear_i) begin
            count_next = '0;
            tick_next = 1'b0;
        end else begin
            count_next = count_reg + PRESCALE_W'(1);
            tick_next = ((count_reg & tap_mask(sel_i)) == tap_mask(sel_i));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg;

endmodule

// ==== src/wit_timer.sv ====
// Watchdog and interval timer with protected register writes and overflow reset requests.
//
// Behaviour
// - Eight-bit readable writable up-counter advances on selected clock pulses while enabled.
// - Wrap from FF to 00 raises overflow pin or interval interrupt per mode.
// - Counter reads zero after reset.
// - Interval overflow sets control flag bit 7; watchdog overflow never sets it.
// - Flag clears by reading one then writing zero, on stop in interval mode, or on watchdog self-reset; writing one does nothing.
// - Writing zero to run enable in interval mode clears the control flag.
// - Mode bit 6 selects interval when 0, watchdog when 1; resets to 0.
// - Watchdog overflow drives the active-low overflow output pin.
// - Interval overflow requests the interval interrupt every time.
// - Run enable bit 5 low forces counter to zero and stops it.
// - Control bits 4 and 3 read as one; software writes ones there.
// - Watchdog overflow may request internal reset, power-on or manual.
// - Three-bit select field chooses one of eight count clocks.
// - Counter and control registers change only through keyed protected writes.
// - Select codes 0 to 7 divide clock by 2,64,128,256,512,1024,4096,8192.
// - Watchdog overflow sets reset-control flag bit 7; read one, write zero clears.
// - Reset enable high requests chip reset; low resets only counter and control.
// - Reset kind bit chooses power-on when 0, manual when 1.
`timescale 1ns/100ps
module wit_timer #(
    parameter int COUNT_W = 8,
    parameter int PULSE_CYCLES = wit_pkg::PULSE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [wit_pkg::ADDR_W-1:0] addr_i,
    input wire logic [wit_pkg::WDATA_W-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [wit_pkg::REG_W-1:0] rdata_o,
    output logic interval_tick_interrupt_o,
    output logic standby_wake_o,
    output logic watchdog_overflow_out_n_o,
    output logic power_on_reset_req_o,
    output logic manual_reset_req_o
);

    if (COUNT_W != 8) begin : g_count_check
        $error("The counter must be eight bits wide.");
    end
    if (PULSE_CYCLES < 8 || PULSE_CYCLES >= (1 << wit_pkg::PULSE_CNT_W)) begin : g_pulse_check
        $error("Overflow pulse length out of range.");
    end

    logic [7:0] counter_reg;
    logic [7:0] counter_next;
    wit_pkg::wit_mode_e mode_reg;
    wit_pkg::wit_mode_e mode_next;
    logic run_reg;
    logic run_next;
    logic [2:0] sel_reg;
    logic [2:0] sel_next;
    logic ctrl_flag_reg;
    logic ctrl_flag_next;
    logic ctrl_armed_reg;
    logic ctrl_armed_next;
    logic wd_flag_reg;
    logic wd_flag_next;
    logic wd_armed_reg;
    logic wd_armed_next;
    logic rst_enable_reg;
    logic rst_enable_next;
    logic rst_kind_reg;
    logic rst_kind_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic wake_reg;
    logic wake_next;

    wit_pkg::wit_pulse_e pulse_state_reg;
    wit_pkg::wit_pulse_e pulse_state_next;
    logic [wit_pkg::PULSE_CNT_W-1:0] pulse_cnt_reg;
    logic [wit_pkg::PULSE_CNT_W-1:0] pulse_cnt_next;
    logic pin_n_reg;
    logic pin_n_next;
    logic por_reg;
    logic por_next;
    logic man_reg;
    logic man_next;

    logic tick;
    logic overflow;
    logic wd_overflow;
    logic int_overflow;
    logic wr_counter;
    logic wr_control;
    logic wr_reset_ctrl;
    logic [7:0] control_view;
    logic [7:0] reset_view;

    wit_prescaler #(
        .PRESCALE_W(wit_pkg::PRESCALE_W)
    ) u_prescaler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(!run_reg),
        .sel_i(sel_reg),
        .tick_o(tick)
    );

    // Decodes a keyed write to one register address.
    function automatic logic keyed_write(input logic we, input logic [1:0] addr, input logic [1:0] target,
                                         input logic [7:0] key, input logic [7:0] expect_key);
        keyed_write = we && (addr == target) && (key == expect_key);
    endfunction

    always_comb begin
        overflow = run_reg && tick && (counter_reg == wit_pkg::COUNTER_MAX);
        wd_overflow = overflow && (mode_reg == wit_pkg::MODE_WATCHDOG);
        int_overflow = overflow && (mode_reg == wit_pkg::MODE_INTERVAL);
        wr_counter = keyed_write(we_i, addr_i, wit_pkg::OFS_COUNTER, wdata_i[15:8], wit_pkg::KEY_COUNTER);
        wr_control = keyed_write(we_i, addr_i, wit_pkg::OFS_CONTROL, wdata_i[15:8], wit_pkg::KEY_CONTROL);
        wr_reset_ctrl = keyed_write(we_i, addr_i, wit_pkg::OFS_RESET_CTRL, wdata_i[15:8], wit_pkg::KEY_CONTROL);
        control_view = wit_pkg::CONTROL_ONES;
        control_view[wit_pkg::CTRL_FLAG_BIT] = ctrl_flag_reg;
        control_view[wit_pkg::CTRL_MODE_BIT] = mode_reg;
        control_view[wit_pkg::CTRL_RUN_BIT] = run_reg;
        control_view[wit_pkg::CTRL_SEL_LSB +: 3] = sel_reg;
        reset_view = wit_pkg::RESET_CTRL_ONES;
        reset_view[wit_pkg::RST_FLAG_BIT] = wd_flag_reg;
        reset_view[wit_pkg::RST_ENABLE_BIT] = rst_enable_reg;
        reset_view[wit_pkg::RST_KIND_BIT] = rst_kind_reg;
    end

    always_comb begin
        counter_next = counter_reg;
        mode_next = mode_reg;
        run_next = run_reg;
        sel_next = sel_reg;
        ctrl_flag_next = ctrl_flag_reg;
        ctrl_armed_next = ctrl_armed_reg;
        wd_flag_next = wd_flag_reg;
        wd_armed_next = wd_armed_reg;
        rst_enable_next = rst_enable_reg;
        rst_kind_next = rst_kind_reg;
        rdata_next = 8'h00;
        wake_next = int_overflow;
        if (run_reg && tick) begin
            counter_next = counter_reg + 8'h01;
        end
        if (wr_counter) begin
            counter_next = wdata_i[7:0];
        end
        if (!run_reg) begin
            counter_next = wit_pkg::COUNTER_RESET;
        end
        if (re_i) begin
            case (addr_i)
                wit_pkg::OFS_COUNTER: begin
                    rdata_next = counter_reg;
                end
                wit_pkg::OFS_CONTROL: begin
                    rdata_next = control_view;
                    ctrl_armed_next = ctrl_flag_reg;
                end
                wit_pkg::OFS_RESET_CTRL: begin
                    rdata_next = reset_view;
                    wd_armed_next = wd_flag_reg;
                end
                default: begin
                    rdata_next = 8'h00;
                end
            endcase
        end
        if (wr_control) begin
            mode_next = wit_pkg::wit_mode_e'(wdata_i[wit_pkg::CTRL_MODE_BIT]);
            run_next = wdata_i[wit_pkg::CTRL_RUN_BIT];
            sel_next = wdata_i[wit_pkg::CTRL_SEL_LSB +: 3];
            if (ctrl_armed_reg && !wdata_i[wit_pkg::CTRL_FLAG_BIT]) begin
                ctrl_flag_next = 1'b0;
            end
            if (!wdata_i[wit_pkg::CTRL_RUN_BIT] && mode_reg == wit_pkg::MODE_INTERVAL) begin
                ctrl_flag_next = 1'b0;
            end
            ctrl_armed_next = 1'b0;
        end
        if (wr_reset_ctrl) begin
            rst_enable_next = wdata_i[wit_pkg::RST_ENABLE_BIT];
            rst_kind_next = wdata_i[wit_pkg::RST_KIND_BIT];
            if (wd_armed_reg && !wdata_i[wit_pkg::RST_FLAG_BIT]) begin
                wd_flag_next = 1'b0;
            end
            wd_armed_next = 1'b0;
        end
        if (int_overflow) begin
            ctrl_flag_next = 1'b1;
        end
        if (wd_overflow) begin
            wd_flag_next = 1'b1;
            if (!rst_enable_reg) begin
                counter_next = wit_pkg::COUNTER_RESET;
                mode_next = wit_pkg::MODE_INTERVAL;
                run_next = 1'b0;
                sel_next = wit_pkg::SEL_RESET;
                ctrl_flag_next = 1'b0;
                ctrl_armed_next = 1'b0;
            end
        end
    end

    always_comb begin
        pulse_state_next = pulse_state_reg;
        pulse_cnt_next = pulse_cnt_reg;
        pin_n_next = pin_n_reg;
        por_next = por_reg;
        man_next = man_reg;
        case (pulse_state_reg)
            wit_pkg::PULSE_IDLE: begin
                if (wd_overflow) begin
                    pulse_state_next = wit_pkg::PULSE_DRIVE;
                    pulse_cnt_next = wit_pkg::PULSE_CNT_W'(PULSE_CYCLES - 1);
                    pin_n_next = 1'b0;
                    por_next = rst_enable_reg && !rst_kind_reg;
                    man_next = rst_enable_reg && rst_kind_reg;
                end
            end
            wit_pkg::PULSE_DRIVE: begin
                if (pulse_cnt_reg == '0) begin
                    pulse_state_next = wit_pkg::PULSE_IDLE;
                    pin_n_next = 1'b1;
                    por_next = 1'b0;
                    man_next = 1'b0;
                end else begin
                    pulse_cnt_next = pulse_cnt_reg - wit_pkg::PULSE_CNT_W'(1);
                end
            end
            default: begin
                pulse_state_next = wit_pkg::PULSE_IDLE;
                pin_n_next = 1'b1;
                por_next = 1'b0;
                man_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            counter_reg <= wit_pkg::COUNTER_RESET;
            mode_reg <= wit_pkg::MODE_INTERVAL;
            run_reg <= 1'b0;
            sel_reg <= wit_pkg::SEL_RESET;
            ctrl_flag_reg <= 1'b0;
            ctrl_armed_reg <= 1'b0;
            wd_flag_reg <= 1'b0;
            wd_armed_reg <= 1'b0;
            rst_enable_reg <= 1'b0;
            rst_kind_reg <= 1'b0;
            rdata_reg <= 8'h00;
            wake_reg <= 1'b0;
            pulse_state_reg <= wit_pkg::PULSE_IDLE;
            pulse_cnt_reg <= '0;
            pin_n_reg <= 1'b1;
            por_reg <= 1'b0;
            man_reg <= 1'b0;
        end else begin
            counter_reg <= counter_next;
            mode_reg <= mode_next;
            run_reg <= run_next;
            sel_reg <= sel_next;
            ctrl_flag_reg <= ctrl_flag_next;
            ctrl_armed_reg <= ctrl_armed_next;
            wd_flag_reg <= wd_flag_next;
            wd_armed_reg <= wd_armed_next;
            rst_enable_reg <= rst_enable_next;
            rst_kind_reg <= rst_kind_next;
            rdata_reg <= rdata_next;
            wake_reg <= wake_next;
            pulse_state_reg <= pulse_state_next;
            pulse_cnt_reg <= pulse_cnt_next;
            pin_n_reg <= pin_n_next;
            por_reg <= por_next;
            man_reg <= man_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign interval_tick_interrupt_o = ctrl_flag_reg;
    assign standby_wake_o = wake_reg;
    assign watchdog_overflow_out_n_o = pin_n_reg;
    assign power_on_reset_req_o = por_reg;
    assign manual_reset_req_o = man_reg;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_pin_low;
        !watchdog_overflow_out_n_o [*8];
    endsequence

    sequence s_interval_event;
        standby_wake_o && interval_tick_interrupt_o;
    endsequence

    property p_count_step;
        run_reg && tick && !wr_counter && !wr_control && counter_reg != wit_pkg::COUNTER_MAX
            |=> counter_reg == $past(counter_reg) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step) else $error("Counter did not advance on a tick.");

    property p_stopped_zero;
        !run_reg |=> counter_reg == 8'h00;
    endproperty
    a_stopped_zero: assert property (p_stopped_zero) else $error("Counter not held at zero while stopped.");

    property p_interval_event;
        int_overflow |=> ctrl_flag_reg ##0 s_interval_event;
    endproperty
    a_interval_event: assert property (p_interval_event) else $error("Interval overflow missed.");

    property p_no_flag_watchdog;
        wd_overflow && !ctrl_flag_reg |=> !ctrl_flag_reg;
    endproperty
    a_no_flag_watchdog: assert property (p_no_flag_watchdog) else $error("Control flag set in watchdog mode.");

    property p_pin_pulse;
        wd_overflow && pulse_state_reg == wit_pkg::PULSE_IDLE |=> wd_flag_reg ##0 s_pin_low;
    endproperty
    a_pin_pulse: assert property (p_pin_pulse) else $error("Overflow pin pulse missing or short.");

    property p_reset_kind;
        wd_overflow && pulse_state_reg == wit_pkg::PULSE_IDLE && rst_enable_reg
            |=> power_on_reset_req_o == !$past(rst_kind_reg) && manual_reset_req_o == $past(rst_kind_reg);
    endproperty
    a_reset_kind: assert property (p_reset_kind) else $error("Wrong internal reset request.");

    property p_self_reset;
        wd_overflow && !rst_enable_reg |=> !run_reg && counter_reg == 8'h00 && !power_on_reset_req_o;
    endproperty
    a_self_reset: assert property (p_self_reset) else $error("Timer not reset on overflow without reset enable.");

    property p_unkeyed_ignored;
        we_i && addr_i == wit_pkg::OFS_CONTROL && wdata_i[15:8] != wit_pkg::KEY_CONTROL && !overflow
            |=> {mode_reg, run_reg, sel_reg} == $past({mode_reg, run_reg, sel_reg});
    endproperty
    a_unkeyed_ignored: assert property (p_unkeyed_ignored) else $error("Unprotected write changed control.");

    property p_reserved_ones;
        re_i && addr_i == wit_pkg::OFS_CONTROL |=> rdata_o[4:3] == 2'b11;
    endproperty
    a_reserved_ones: assert property (p_reserved_ones) else $error("Reserved control bits not read as one.");

    property p_write_one_no_set;
        wr_control && wdata_i[wit_pkg::CTRL_FLAG_BIT] && !ctrl_flag_reg && !overflow |=> !ctrl_flag_reg;
    endproperty
    a_write_one_no_set: assert property (p_write_one_no_set) else $error("Writing one set the flag.");

    property p_clear_after_read;
        re_i && addr_i == wit_pkg::OFS_CONTROL && ctrl_flag_reg && !overflow
            ##1 wr_control && !wdata_i[wit_pkg::CTRL_FLAG_BIT] && !overflow |=> !ctrl_flag_reg;
    endproperty
    a_clear_after_read: assert property (p_clear_after_read) else $error("Flag not cleared after read and write.");

endmodule

// ==== bench/wit_timer_tb.sv ====
// Self-checking testbench for the watchdog interval timer.
`timescale 1ns/100ps
module wit_timer_tb;
    localparam int PULSE = 8;
    localparam int LIMIT = 60000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [wit_pkg::ADDR_W-1:0] addr_i = '0;
    logic [wit_pkg::WDATA_W-1:0] wdata_i = '0;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic [wit_pkg::REG_W-1:0] rdata_o;
    logic irq;
    logic wake;
    logic pin_n;
    logic por;
    logic man;
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;

    wit_timer #(.COUNT_W(8), .PULSE_CYCLES(PULSE)) u_dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .we_i(we_i),
        .re_i(re_i),
        .rdata_o(rdata_o),
        .interval_tick_interrupt_o(irq),
        .standby_wake_o(wake),
        .watchdog_overflow_out_n_o(pin_n),
        .power_on_reset_req_o(por),
        .manual_reset_req_o(man)
    );

    always #5 clk_i = ~clk_i;

    task automatic conclude();
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Cuts a hang short.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fails = fails + 1;
            conclude();
        end
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_i);
        we_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk_i);
        re_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask

    task automatic rchk(input string name, input logic [1:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(name, {8'h00, v}, {8'h00, exp});
    endtask

    task automatic wc(input logic [7:0] v);
        wr(wit_pkg::OFS_CONTROL, {wit_pkg::KEY_CONTROL, v});
    endtask

    // Reads the control register and writes it with a key in the very next cycle.
    task automatic rd_then_wc(input logic [7:0] wv, output logic [7:0] v);
        @(posedge clk_i);
        re_i <= 1'b1;
        addr_i <= wit_pkg::OFS_CONTROL;
        @(posedge clk_i);
        re_i <= 1'b0;
        we_i <= 1'b1;
        wdata_i <= {wit_pkg::KEY_CONTROL, wv};
        #1;
        v = rdata_o;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask

    task automatic wait_wake();
        int n;
        n = 0;
        while (wake !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("wake pulse", {15'h0, wake}, 16'h0001);
    endtask

    // Reset values, reserved bits, keyed writes and the unmapped address.
    task automatic t_regs();
        rchk("counter reset", wit_pkg::OFS_COUNTER, 8'h00);
        rchk("control reset", wit_pkg::OFS_CONTROL, 8'h18);
        rchk("reset ctrl reset", wit_pkg::OFS_RESET_CTRL, 8'h1F);
        chk("idle outputs", {11'h0, irq, wake, pin_n, por, man}, 16'h0004);
        wr(wit_pkg::OFS_CONTROL, 16'h0038);
        rchk("unkeyed control", wit_pkg::OFS_CONTROL, 8'h18);
        wc(8'h3B);
        rchk("keyed control", wit_pkg::OFS_CONTROL, 8'h3B);
        wr(wit_pkg::OFS_COUNTER, {wit_pkg::KEY_COUNTER, 8'h80});
        rchk("keyed counter", wit_pkg::OFS_COUNTER, 8'h80);
        wr(wit_pkg::OFS_COUNTER, 16'h0011);
        rchk("unkeyed counter", wit_pkg::OFS_COUNTER, 8'h80);
        wr(2'h3, 16'hA5FF);
        rchk("unmapped read", 2'h3, 8'h00);
        wc(8'h18);
        rchk("reserved ones", wit_pkg::OFS_CONTROL, 8'h18);
        rchk("stopped counter", wit_pkg::OFS_COUNTER, 8'h00);
    endtask

    // Interval overflows, flag protection and clearing.
    task automatic t_interval();
        logic [7:0] v;
        wc(8'h98);
        rchk("flag write one", wit_pkg::OFS_CONTROL, 8'h18);
        wc(8'h38);
        wr(wit_pkg::OFS_COUNTER, {wit_pkg::KEY_COUNTER, 8'hFE});
        wait_wake();
        chk("interrupt", {15'h0, irq}, 16'h0001);
        chk("pin idle interval", {15'h0, pin_n}, 16'h0001);
        @(posedge clk_i);
        #1;
        chk("wake one cycle", {15'h0, wake}, 16'h0000);
        wc(8'h3F);
        rd_then_wc(8'h3F, v);
        chk("flag unarmed", {8'h00, v}, 16'h00BF);
        rchk("flag cleared", wit_pkg::OFS_CONTROL, 8'h3F);
        chk("interrupt off", {15'h0, irq}, 16'h0000);
        wc(8'h38);
        wr(wit_pkg::OFS_COUNTER, {wit_pkg::KEY_COUNTER, 8'hFE});
        wait_wake();
        wc(8'h18);
        rchk("stop clears flag", wit_pkg::OFS_CONTROL, 8'h18);
        rchk("stop zero count", wit_pkg::OFS_COUNTER, 8'h00);
        chk("interrupt stop", {15'h0, irq}, 16'h0000);
    endtask

    // Watchdog overflow with one reset-control setting.
    task automatic wd_case(input logic [7:0] rc, input logic exp_por, input logic exp_man);
        int n;
        logic [7:0] v;
        do_reset();
        wr(wit_pkg::OFS_RESET_CTRL, {wit_pkg::KEY_CONTROL, rc});
        wc(8'h78);
        wr(wit_pkg::OFS_COUNTER, {wit_pkg::KEY_COUNTER, 8'hFE});
        n = 0;
        while (pin_n !== 1'b0 && n < 100) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("pin low", {15'h0, pin_n}, 16'h0000);
        chk("power-on request", {15'h0, por}, {15'h0, exp_por});
        chk("manual request", {15'h0, man}, {15'h0, exp_man});
        chk("no interrupt", {15'h0, irq}, 16'h0000);
        n = 0;
        while (pin_n === 1'b0 && n < 100) begin
            n++;
            @(posedge clk_i);
            #1;
        end
        chk("pin low cycles", n[15:0], 16'(PULSE));
        rchk("watchdog flag", wit_pkg::OFS_RESET_CTRL, {1'b1, rc[6:5], 5'h1F});
        rchk("control after", wit_pkg::OFS_CONTROL, rc[6] ? 8'h78 : 8'h18);
        rd(wit_pkg::OFS_RESET_CTRL, v);
        wr(wit_pkg::OFS_RESET_CTRL, {wit_pkg::KEY_CONTROL, rc});
        rchk("watchdog flag clear", wit_pkg::OFS_RESET_CTRL, {1'b0, rc[6:5], 5'h1F});
    endtask

    // Delay to the first count for every clock select code.
    task automatic t_select();
        int k[8];
        int t0;
        int d;
        logic [7:0] v;
        k = '{1, 6, 7, 8, 9, 10, 12, 13};
        for (int s = 0; s < 8; s++) begin
            wc(8'h38 | 8'(s));
            t0 = cyc;
            v = 8'h00;
            while (v === 8'h00 && cyc - t0 < 9000) begin
                rd(wit_pkg::OFS_COUNTER, v);
            end
            d = cyc - t0;
            chk("first tick", {15'h0, d >= (1 << k[s]) && d <= (1 << k[s]) + 8}, 16'h0001);
            wc(8'h18);
        end
    endtask

    initial begin
        do_reset();
        t_regs();
        t_interval();
        wd_case(8'h00, 1'b0, 1'b0);
        wd_case(8'h40, 1'b1, 1'b0);
        wd_case(8'h60, 1'b0, 1'b1);
        do_reset();
        t_select();
        conclude();
    end
endmodule
